// file: src/reset_strap_config_loader.sv
// Reset-time strap capture and the control registers it presets
//
// What this block does
// [R01] Board keeps all eight strap inputs at steady levels when hardware reset ends.
// [R02] Station address strap is stored when hardware reset ends.
// [R03] Management frames answered only when their address equals the stored address.
// [R04] Stored address seeds the transmit scrambler.
// [R05] Hardware reset release loads control 13,12,10,8 and advertise 8:5 from mode.
// [R06] Software reset configures from register values; mode pins are ignored.
// [R07] Mode 000: 10M half duplex, no autoneg, control bits 0000.
// [R08] Mode 001: 10M full duplex, no autoneg, control bits 0001.
// [R09] Mode 010: 100M half duplex, control 1000, carrier sense on transmit and receive.
// [R10] Mode 011: 100M full duplex, control 1001, carrier sense on receive only.
// [R11] Mode 100: autoneg 100M half only, control 1100, advertise 0100.
// [R12] Mode 101: repeater, control 1100, advertise 0100, carrier sense receive only.
// [R13] Mode 110 powers down; leave by new mode field then software reset.
// [R14] Mode 111: autoneg all abilities, control X10X, advertise 1111.
// [R15] Control bit 15 starts self-clearing software reset stretched 256 us.
// [R16] Each of stored address bits 3:0 that is one makes its indicator output active low.
// [R17] Address and mode straps sampled together at synchronised reset rising edge.
// [R18] Unspecified control bits keep their ordinary reset values; a software reset leaves them at their register values.
`timescale 1ns/1ps
`include "strap_map.svh"
module reset_strap_config_loader
  import strap_pkg::*;
#(
  parameter int SOFT_RST_CYCLES = `SOFT_RST_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hardware_reset_n,
  input  wire logic [4:0]  station_address_strap,
  input  wire logic [2:0]  mode_strap,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [4:0]  frame_addr,
  input  wire logic        frame_addr_valid,
  output logic             frame_match,
  input  wire logic        scr_step,
  output logic             scr_bit,
  input  wire logic [3:0]  led_raw,
  output logic      [3:0]  led_pin,
  output logic             powered_down,
  output logic             crs_on_tx,
  output logic             repeater_mode,
  output logic             config_ready,
  output logic             soft_reset_busy
);
  localparam logic [15:0] CTRL_RST_V = `CTRL_RST;
  localparam logic [15:0] ADV_RST_V  = `ADV_RST;
  localparam cfg_s        CFG_RST    = '{ctrl: `CTRL_RST, adv: `ADV_RST};

  if (SOFT_RST_CYCLES < 1) begin : g_bad_soft
    $error("reset_strap_config_loader: SOFT_RST_CYCLES must be at least 1");
  end

  // Places a four-bit pattern on control bits 13,12,10,8
  function automatic logic [15:0] put_ctrl(input logic [15:0] c, input logic [3:0] p);
    logic [15:0] r;
    r = c;
    r[`CTRL_SPEED]  = p[3];
    r[`CTRL_ANEG]   = p[2];
    r[`CTRL_ISO]    = p[1];
    r[`CTRL_DUPLEX] = p[0];
    return r;
  endfunction

  // Configuration preset for one mode value
  function automatic cfg_s mode_apply(input logic [2:0] m, input cfg_s c);
    cfg_s r;
    r = c;
    r.ctrl[`CTRL_SOFT]  = 1'b0;
    r.ctrl[`CTRL_PDOWN] = 1'b0;
    case (m)
      MODE_10HD:     r.ctrl = put_ctrl(r.ctrl, 4'b0000); // R07
      MODE_10FD:     r.ctrl = put_ctrl(r.ctrl, 4'b0001); // R08
      MODE_100HD:    r.ctrl = put_ctrl(r.ctrl, 4'b1000); // R09
      MODE_100FD:    r.ctrl = put_ctrl(r.ctrl, 4'b1001); // R10
      MODE_AN100HD, MODE_REPEATER: begin // R11 R12
        r.ctrl      = put_ctrl(r.ctrl, 4'b1100);
        r.adv[8:5]  = 4'b0100;
      end
      MODE_PDOWN:    r.ctrl[`CTRL_PDOWN] = 1'b1; // R13
      MODE_ALL: begin // R14 R18
        r.ctrl[`CTRL_ANEG] = 1'b1;
        r.ctrl[`CTRL_ISO]  = 1'b0;
        r.adv[8:5]         = 4'b1111;
      end
      default:       r = c;
    endcase
    return r;
  endfunction

  // Pin inputs
  logic [8:0] pins_s;
  logic       hw_n_s;
  logic [4:0] addr_s;
  logic [2:0] mode_s;

  strap_sync #(
    .W (9)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({hardware_reset_n, station_address_strap, mode_strap}),
    .q       (pins_s)
  );

  assign hw_n_s = pins_s[8];
  assign addr_s = pins_s[7:3];
  assign mode_s = pins_s[2:0];

  logic hw_n_prev_q;
  logic hw_rise;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hw_n_prev_q <= 1'b0;
    end else begin
      hw_n_prev_q <= hw_n_s;
    end
  end

  assign hw_rise = hw_n_s && !hw_n_prev_q; // R17

  // Register port decode
  logic wr_ctrl;
  logic wr_adv;
  logic wr_spc;
  logic soft_start;
  logic soft_done;

  assign wr_ctrl    = reg_wr && hw_n_s && (reg_addr == `REG_CTRL);
  assign wr_adv     = reg_wr && hw_n_s && (reg_addr == `REG_ADV);
  assign wr_spc     = reg_wr && hw_n_s && (reg_addr == `REG_SPECIAL);
  assign soft_start = wr_ctrl && reg_wdata[`CTRL_SOFT]; // R15

  strap_soft_reset #(
    .CYCLES (SOFT_RST_CYCLES)
  ) u_soft (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (soft_start),
    .abort   (!hw_n_s),
    .busy    (soft_reset_busy),
    .done    (soft_done)
  );

  // Loader sequence
  loader_state_e state_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !hw_n_s) begin
      state_q <= LD_HOLD;
    end else begin
      case (state_q)
        LD_HOLD: begin
          if (hw_rise) begin
            state_q <= LD_RUN;
          end
        end
        LD_RUN: begin
          if (soft_start) begin
            state_q <= LD_SOFT;
          end
        end
        LD_SOFT: begin
          if (soft_done) begin
            state_q <= LD_RUN;
          end
        end
        default: state_q <= LD_HOLD;
      endcase
    end
  end

  // Strap-derived fields of the special-modes register
  logic [4:0] addr_q;
  logic [2:0] mode_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !hw_n_s) begin
      addr_q <= 5'h00;
      mode_q <= 3'h0;
    end else if (hw_rise) begin
      addr_q <= addr_s; // R02 R17
      mode_q <= mode_s;
    end else if (wr_spc) begin
      mode_q <= reg_wdata[`SPC_MODE_LSB +: 3]; // R13
    end
  end

  // Control and advertisement registers
  logic [15:0] ctrl_q;
  logic [15:0] adv_q;
  cfg_s        cfg_hw;
  cfg_s        cfg_sw;

  assign cfg_hw = mode_apply(mode_s, CFG_RST); // R05
  assign cfg_sw = mode_apply(mode_q, '{ctrl: ctrl_q, adv: adv_q}); // R06

  always_ff @(posedge clk) begin
    if (sys_rst || !hw_n_s) begin
      ctrl_q <= `CTRL_RST;
      adv_q  <= `ADV_RST;
    end else if (hw_rise) begin
      ctrl_q <= cfg_hw.ctrl; // R05
      adv_q  <= cfg_hw.adv;
    end else if (soft_done && state_q == LD_SOFT) begin
      ctrl_q <= cfg_sw.ctrl; // R06 R13
      adv_q  <= cfg_sw.adv;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= (ctrl_q & ~`CTRL_WMASK) | (reg_wdata & `CTRL_WMASK);
      end
      if (wr_adv) begin
        adv_q <= (adv_q & ~`ADV_WMASK) | (reg_wdata & `ADV_WMASK);
      end
    end
  end

  // Read data, valid only in the cycle after the strobe
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    case (reg_addr)
      `REG_CTRL:    rd_mux = {soft_reset_busy, ctrl_q[14:0]}; // R15
      `REG_ADV:     rd_mux = adv_q;
      `REG_SPECIAL: rd_mux = {8'h00, mode_q, addr_q};
      default:      rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // Management frame address match
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_match <= 1'b0;
    end else begin
      frame_match <= frame_addr_valid && (state_q != LD_HOLD)
                     && (frame_addr == addr_q); // R03
    end
  end

  // Transmit scrambler, seeded from the station address
  logic [10:0] lfsr_q;
  logic        lfsr_fb;
  assign lfsr_fb = lfsr_q[10] ^ lfsr_q[8];

  always_ff @(posedge clk) begin
    if (sys_rst || !hw_n_s) begin
      lfsr_q <= {5'h00, `SCR_FILL};
    end else if (hw_rise) begin
      lfsr_q <= {addr_s, `SCR_FILL}; // R04
    end else if (soft_done && state_q == LD_SOFT) begin
      lfsr_q <= {addr_q, `SCR_FILL}; // R04
    end else if (scr_step) begin
      lfsr_q <= {lfsr_q[9:0], lfsr_fb};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !hw_n_s) begin
      scr_bit <= 1'b0;
    end else if (scr_step) begin
      scr_bit <= lfsr_fb;
    end
  end

  // Indicator polarity follows the stored address bits
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_pin <= 4'h0;
    end else begin
      led_pin <= led_raw ^ addr_q[3:0]; // R16
    end
  end

  // Status outputs derived from the configuration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      powered_down  <= 1'b0;
      crs_on_tx     <= 1'b0;
      repeater_mode <= 1'b0;
      config_ready  <= 1'b0;
    end else begin
      powered_down  <= ctrl_q[`CTRL_PDOWN]; // R13
      repeater_mode <= (state_q != LD_HOLD) && (mode_q == MODE_REPEATER); // R12
      crs_on_tx     <= !ctrl_q[`CTRL_DUPLEX] && (mode_q != MODE_REPEATER); // R09 R10
      config_ready  <= (state_q == LD_RUN);
    end
  end

  // Cycle counter for the software reset stretch check
  int busy_len_q;

  always_ff @(posedge clk) begin
    if (sys_rst || soft_start || !soft_reset_busy) begin
      busy_len_q <= 0;
    end else begin
      busy_len_q <= busy_len_q + 1;
    end
  end

  AST_ADDR_LATCH: assert property ( // R02
    @(posedge clk) disable iff (sys_rst)
    hw_rise |=> (addr_q == $past(addr_s)) && (state_q == LD_RUN)
  ) else $error("address not stored at reset release");
  AST_FRAME_MATCH: assert property ( // R03
    @(posedge clk) disable iff (sys_rst)
    frame_match |-> $past(frame_addr_valid) && ($past(frame_addr) == $past(addr_q))
  ) else $error("frame matched a foreign address");
  AST_SEED: assert property ( // R04
    @(posedge clk) disable iff (sys_rst)
    hw_rise |=> lfsr_q == {$past(addr_s), `SCR_FILL}
  ) else $error("scrambler not seeded from address");
  AST_M000: assert property ( // R07
    @(posedge clk) disable iff (sys_rst)
    hw_rise && mode_s == 3'b000 |=> {ctrl_q[13], ctrl_q[12], ctrl_q[10], ctrl_q[8]} == 4'b0000
  ) else $error("mode 000 preset wrong");
  AST_M011: assert property ( // R10
    @(posedge clk) disable iff (sys_rst)
    hw_rise && mode_s == 3'b011 |=> {ctrl_q[13], ctrl_q[12], ctrl_q[10], ctrl_q[8]} == 4'b1001 ##1 !crs_on_tx
  ) else $error("mode 011 preset wrong");
  AST_M101: assert property ( // R12
    @(posedge clk) disable iff (sys_rst)
    hw_rise && mode_s == 3'b101 |=> ctrl_q[12] && adv_q[8:5] == 4'b0100 ##1 repeater_mode
  ) else $error("mode 101 preset wrong");
  AST_M111: assert property ( // R14
    @(posedge clk) disable iff (sys_rst)
    hw_rise && mode_s == 3'b111 |=> ctrl_q[12] && !ctrl_q[10] && adv_q[8:5] == 4'b1111
  ) else $error("mode 111 preset wrong");
  AST_NA_KEEP: assert property ( // R18
    @(posedge clk) disable iff (sys_rst)
    hw_rise && mode_s == 3'b111 |=> ctrl_q[13] == CTRL_RST_V[13] && ctrl_q[8] == CTRL_RST_V[8]
  ) else $error("unspecified control bits disturbed");
  AST_NA_ADV: assert property ( // R18
    @(posedge clk) disable iff (sys_rst)
    hw_rise && !mode_s[2] |=> adv_q == ADV_RST_V
  ) else $error("advertisement changed for fixed mode");
  AST_PDOWN: assert property ( // R13
    @(posedge clk) disable iff (sys_rst)
    hw_rise && mode_s == 3'b110 |=> ctrl_q[11] ##1 powered_down
  ) else $error("mode 110 did not power down");
  AST_SOFT_CFG: assert property ( // R06
    @(posedge clk) disable iff (sys_rst)
    soft_done && state_q == LD_SOFT && hw_n_s |=> ctrl_q[11] == ($past(mode_q) == MODE_PDOWN) && $stable(addr_q)
  ) else $error("software reset did not use register mode");
  AST_SOFT_LEN: assert property ( // R15
    @(posedge clk) disable iff (sys_rst || !hw_n_s)
    $fell(soft_reset_busy) |-> busy_len_q == SOFT_RST_CYCLES
  ) else $error("software reset stretch length wrong");
  AST_SOFT_BIT: assert property ( // R15
    @(posedge clk) disable iff (sys_rst)
    soft_start |=> soft_reset_busy ##1 soft_reset_busy || soft_done
  ) else $error("software reset bit did not set");
  AST_LED: assert property ( // R16
    @(posedge clk) disable iff (sys_rst)
    ##1 led_pin == ($past(led_raw) ^ $past(addr_q[3:0]))
  ) else $error("indicator polarity wrong");
endmodule

// file: shared/strap_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef STRAP_MAP_SVH
`define STRAP_MAP_SVH
`define REG_CTRL     5'h00
`define REG_ADV      5'h04
`define REG_SPECIAL  5'h12
`define CTRL_RST     16'h3100
`define ADV_RST      16'h01e1
`define CTRL_WMASK   16'h7f80
`define ADV_WMASK    16'h01e0
`define CTRL_SOFT    15
`define CTRL_SPEED   13
`define CTRL_ANEG    12
`define CTRL_PDOWN   11
`define CTRL_ISO     10
`define CTRL_DUPLEX  8
`define ADV_LSB      5
`define SPC_MODE_LSB 5
`define SCR_FILL     6'h3f
`define CLK_NS       25
`define SOFT_RST_NS  256000
`define SOFT_RST_CYC ((`SOFT_RST_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: shared/strap_pkg.sv
// Types shared by the strap loader modules
package strap_pkg;
  typedef enum logic [2:0] {
    MODE_10HD     = 3'b000,
    MODE_10FD     = 3'b001,
    MODE_100HD    = 3'b010,
    MODE_100FD    = 3'b011,
    MODE_AN100HD  = 3'b100,
    MODE_REPEATER = 3'b101,
    MODE_PDOWN    = 3'b110,
    MODE_ALL      = 3'b111
  } strap_mode_e;

  typedef enum logic [1:0] {
    LD_HOLD = 2'b00,
    LD_RUN  = 2'b01,
    LD_SOFT = 2'b10
  } loader_state_e;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] adv;
  } cfg_s;
endpackage

// file: src/strap_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module strap_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  if (W < 1) begin : g_bad_width
    $error("strap_sync: W must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule

// file: src/strap_soft_reset.sv
// Stretches a software reset request to a fixed number of cycles
`timescale 1ns/1ps
module strap_soft_reset #(
  parameter int CYCLES = 10240
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic abort,
  output logic      busy,
  output logic      done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;

  if (CYCLES < 1) begin : g_bad_cycles
    $error("strap_soft_reset: CYCLES must be at least 1");
  end

  always_ff @(posedge clk) begin
    if (sys_rst || abort) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      cnt_q <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        // A new request restarts the stretch
        busy  <= 1'b1;
        cnt_q <= '0;
      end else if (busy) begin
        if (cnt_q == LAST) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  end
endmodule

// file: dv/strap_board_model.sv
// Board strap resistors and reset pin driver for the strap loader
`timescale 1ns/1ps
module strap_board_model (
  input  wire logic       clk,
  output logic            hardware_reset_n,
  output logic      [4:0] station_address_strap,
  output logic      [2:0] mode_strap
);
  initial begin
    hardware_reset_n      = 1'b0;
    station_address_strap = 5'h00;
    mode_strap            = 3'h0;
  end

  // Straps move only while reset is low, then stay steady
  task automatic pulse_reset(input logic [4:0] a, input logic [2:0] m);
    @(posedge clk);
    hardware_reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    station_address_strap <= a;
    mode_strap            <= m;
    repeat (8) @(posedge clk);
    hardware_reset_n <= 1'b1;
  endtask

  // Deliberate strap change while the device runs
  task automatic drift(input logic [4:0] a, input logic [2:0] m);
    @(posedge clk);
    station_address_strap <= a;
    mode_strap            <= m;
  endtask
endmodule

// file: dv/tb_reset_strap_config_loader.sv
// Self-checking bench for the strap loader
`timescale 1ns/1ps
`include "strap_map.svh"
module tb_reset_strap_config_loader;
  import strap_pkg::*;
  localparam int SRC = 4;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hardware_reset_n;
  logic [4:0]  station_address_strap;
  logic [2:0]  mode_strap;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [4:0]  frame_addr = 5'h00;
  logic        frame_addr_valid = 1'b0;
  logic        frame_match;
  logic        scr_step = 1'b0;
  logic        scr_bit;
  logic [3:0]  led_raw = 4'h0;
  logic [3:0]  led_pin;
  logic        powered_down;
  logic        crs_on_tx;
  logic        repeater_mode;
  logic        config_ready;
  logic        soft_reset_busy;
  int          miscompares = 0;
  int          n_compared = 0;
  logic [15:0] ectl [8] = '{16'h0000, 16'h0100, 16'h2000, 16'h2100, 16'h3000, 16'h3000, 16'h3900, 16'h3100};
  logic [15:0] eadv [8] = '{16'h01e1, 16'h01e1, 16'h01e1, 16'h01e1, 16'h0081, 16'h0081, 16'h01e1, 16'h01e1};
  logic [7:0]  ecrs = 8'h15;

  always #12.5 clk = ~clk;

  strap_board_model u_board (
    .clk                   (clk),
    .hardware_reset_n      (hardware_reset_n),
    .station_address_strap (station_address_strap),
    .mode_strap            (mode_strap)
  );

  reset_strap_config_loader #(.SOFT_RST_CYCLES(SRC)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .hardware_reset_n(hardware_reset_n),
    .station_address_strap(station_address_strap), .mode_strap(mode_strap),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .frame_addr(frame_addr), .frame_addr_valid(frame_addr_valid), .frame_match(frame_match),
    .scr_step(scr_step), .scr_bit(scr_bit), .led_raw(led_raw), .led_pin(led_pin),
    .powered_down(powered_down), .crs_on_tx(crs_on_tx), .repeater_mode(repeater_mode),
    .config_ready(config_ready), .soft_reset_busy(soft_reset_busy)
  );

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    while (config_ready !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(16'(n < 50), 16'h0001);
  endtask

  task automatic t_frame(input logic [4:0] a);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      frame_addr       <= a ^ 5'(k);
      frame_addr_valid <= 1'b1;
      @(posedge clk);
      frame_addr_valid <= 1'b0;
      #1 check(16'(frame_match), 16'(k == 0));
    end
  endtask

  task automatic t_modes();
    logic [15:0] v;
    logic [4:0]  a;
    for (int m = 0; m < 8; m++) begin
      a = 5'(m * 5 + 3);
      u_board.pulse_reset(a, 3'(m));
      wait_ready();
      rd(`REG_CTRL, v);
      check(v, ectl[m]);
      rd(`REG_ADV, v);
      check(v, eadv[m]);
      rd(`REG_SPECIAL, v);
      check(v, {8'h00, 3'(m), a});
      check(16'(crs_on_tx), 16'(ecrs[m]));
      check(16'(repeater_mode), 16'(m == 5));
      check(16'(powered_down), 16'(m == 6));
      @(posedge clk);
      led_raw <= 4'h6;
      @(posedge clk);
      #1 check(16'(led_pin), 16'(4'h6 ^ a[3:0]));
      t_frame(a);
    end
  endtask

  task automatic t_drift();
    logic [15:0] v;
    u_board.drift(5'h1b, 3'h2);
    repeat (4) @(posedge clk);
    rd(`REG_SPECIAL, v);
    check(v, 16'h00e6);
    t_frame(5'h06);
  endtask

  task automatic t_scr();
    logic [10:0] l;
    logic        fb;
    u_board.pulse_reset(5'h13, 3'h3);
    wait_ready();
    l = {5'h13, `SCR_FILL};
    @(posedge clk);
    scr_step <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      #1 fb = l[10] ^ l[8];
      l = {l[9:0], fb};
      check(16'(scr_bit), 16'(fb));
    end
    @(posedge clk);
    scr_step <= 1'b0;
  endtask

  task automatic t_soft();
    logic [15:0] v;
    int          n;
    u_board.pulse_reset(5'h0a, 3'h6);
    wait_ready();
    check(16'(powered_down), 16'h0001);
    u_board.drift(5'h0a, 3'h7);
    wr(`REG_SPECIAL, 16'h005f);
    rd(`REG_SPECIAL, v);
    check(v, 16'h004a);
    wr(`REG_CTRL, 16'h8000);
    n = 0;
    #1;
    repeat (40) begin
      if (soft_reset_busy === 1'b1) n++;
      @(posedge clk);
      #1;
    end
    check(16'(n), 16'(SRC));
    wait_ready();
    rd(`REG_CTRL, v);
    check(v, 16'h2000);
    check(16'(powered_down), 16'h0000);
    wr(`REG_CTRL, 16'h8000);
    rd(`REG_CTRL, v);
    check(16'(v[15]), 16'h0001);
    wait_ready();
    rd(`REG_CTRL, v);
    check(16'(v[15]), 16'h0000);
    wr(5'h07, 16'hffff);
    rd(5'h07, v);
    check(v, 16'h0000);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    t_modes();
    t_drift();
    t_scr();
    t_soft();
    complete_run();
  end

  initial begin
    #500000;
    miscompares++;
    complete_run();
  end
endmodule
